// *** src/sync_hub_pkg.sv ***
/*
  package for the multi card sync hub: register indices, command bit positions,
  member count and sequencing constants.
  assumes a simple indexed register port in the hub card's clock domain.
*/
package sync_hub_pkg;
  // number of member card slots (one mask bit each)
  localparam int unsigned CARDS = 16;
  // register indices as printed (kept as indices, not byte offsets)
  localparam logic [15:0] REG_CMD_WORD = 16'h0064;
  localparam logic [15:0] REG_MEMBER_MASK = 16'hC030;
  // reset value of the member mask
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // command bit positions
  localparam int unsigned BIT_FULL_RESET = 0;
  localparam int unsigned BIT_LOAD_CONFIG = 1;
  localparam int unsigned BIT_RUN_BEGIN = 2;
  localparam int unsigned BIT_TRIG_ARM = 3;
  localparam int unsigned BIT_TRIG_FORCE = 4;
  localparam int unsigned BIT_TRIG_DISARM = 5;
  localparam int unsigned BIT_RUN_HALT = 6;
  localparam int unsigned BIT_WAIT_DONE = 8;
  // cycles the sync stage lasts before the first forwarded command pulse
  localparam logic [3:0] SYNC_CYCLES = 4'h4;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SYNC, ST_RESET, ST_LOAD, ST_START, ST_TRIG, ST_HALT} seq_state_t;
endpackage : sync_hub_pkg

// *** src/multi_card_sync_hub.sv ***
/*
  multi card sync hub: joins member cards into one group, takes host commands
  from the command word and forwards them to members in order, ORs member triggers.
  assumes a register port on the hub card clock, one-cycle write/read strobes,
  and member status/trigger inputs arriving from other cards (synchronised here).
*/
// What this block does
// [RULE1] read/write member mask register selects group
// [RULE2] mask bit i is logical card i
// [RULE3] unmasked cards get no group commands
// [RULE4] host always sets the hub card bit
// [RULE5] any member trigger fires whole group
// [RULE6] per-card trigger sources pass through unchanged
// [RULE7] command: check, synchronise, then forward ordered
// [RULE8] write-only command word executes set bits
// [RULE9] bit 0x1 resets member cards fully
// [RULE10] bit 0x2 loads config, no start
// [RULE11] bit 0x4 loads changed config, then starts
// [RULE12] running run blocks config changes
// [RULE13] bit 0x8 arms triggers, with or after start
// [RULE14] bit 0x10 forces trigger immediately
// [RULE15] bit 0x20 disarms; triggers ignored until rearmed
// [RULE16] run starts with trigger disarmed
// [RULE17] bit 0x40 stops run; idle means nothing
// [RULE18] other settings go directly to cards
// [RULE19] wait completes when hub card ready
// [RULE20] start executes before arm in same write
`timescale 1ns/100ps
module multi_card_sync_hub (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_index_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_err_out,
  // host side config change notice
  input wire logic config_changed_in,
  // per-member inputs from cards
  input wire logic [15:0] member_trig_in,
  input wire logic [15:0] member_ready_in,
  // hub card position
  input wire logic [3:0] hub_index_in,
  // per-member command strobes
  output logic [15:0] cmd_full_reset_out,
  output logic [15:0] cmd_load_config_out,
  output logic [15:0] cmd_run_begin_out,
  output logic [15:0] cmd_trig_force_out,
  output logic [15:0] cmd_run_halt_out,
  output logic [15:0] sync_pulse_out,
  // group state
  output logic [15:0] group_trig_out,
  output logic [15:0] trig_armed_out,
  output logic run_active_out,
  output logic busy_out,
  output logic wait_done_out
);

  // member mask register, low 16 bits used
  logic [15:0] member_mask;
  // mask latched at check time, held for the run
  logic [15:0] run_mask;
  // pending command bits
  logic [7:0] pend;
  logic wait_pend;
  // sequencer
  sync_hub_pkg::seq_state_t state;
  logic [3:0] sync_cnt;
  // trigger detection armed and run state
  logic armed;
  logic running;
  // config changed since it was last written to the members
  logic dirty;
  // this command walk really sends a load pulse
  logic load_now;
  // two-flop synchronisers for card inputs
  logic [15:0] trig_meta, trig_sync;
  logic [15:0] ready_meta, ready_sync;

  // fan a pulse out to the members of the run
  function automatic logic [15:0] fan(input logic en, input logic [15:0] mask);
    fan = en ? mask : 16'h0000;
  endfunction : fan

  // card-side inputs come from other clock domains
  always_ff @(posedge clk_in) begin
    trig_meta <= member_trig_in;
    trig_sync <= trig_meta;
    ready_meta <= member_ready_in;
    ready_sync <= ready_meta;
  end

  // mask register: writable only outside a run
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      member_mask <= sync_hub_pkg::MASK_RESET[15:0];
    end else if (reg_wr_in && reg_index_in == sync_hub_pkg::REG_MEMBER_MASK && !running) begin
      member_mask <= reg_wdata_in[15:0]; // see [RULE1] see [RULE2] see [RULE12]
    end
  end

  // register read and error answer; command word reads zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      reg_err_out <= 1'b0;
    end else begin
      reg_err_out <= 1'b0;
      if (reg_rd_in) begin
        reg_rdata_out <= (reg_index_in == sync_hub_pkg::REG_MEMBER_MASK) ? {16'h0000, member_mask} : 32'h0000_0000;
      end
      // mask writes during a run are refused and flagged
      if (reg_wr_in && reg_index_in == sync_hub_pkg::REG_MEMBER_MASK && running) begin
        reg_err_out <= 1'b1; // see [RULE12]
      end
    end
  end

  // load decision shared by the sequencer view and the dirty flag
  assign load_now = !running && (pend[sync_hub_pkg::BIT_LOAD_CONFIG] || (pend[sync_hub_pkg::BIT_RUN_BEGIN] && dirty));

  // config changed since last load; a change in the load cycle wins over the clear,
  // and only a real load pulse clears it, so a reset-only walk keeps it pending
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dirty <= 1'b1;
    end else if (config_changed_in || (reg_wr_in && reg_index_in == sync_hub_pkg::REG_MEMBER_MASK && !running)) begin
      dirty <= 1'b1; // see [RULE11]
    end else if (state == sync_hub_pkg::ST_LOAD && load_now) begin
      dirty <= 1'b0;
    end
  end

  // command sequencer: check, sync, then reset, load, start, trigger, halt
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= sync_hub_pkg::ST_IDLE;
      pend <= 8'h00;
      run_mask <= 16'h0000;
      sync_cnt <= 4'h0;
      running <= 1'b0;
      armed <= 1'b0;
      cmd_full_reset_out <= 16'h0000;
      cmd_load_config_out <= 16'h0000;
      cmd_run_begin_out <= 16'h0000;
      cmd_trig_force_out <= 16'h0000;
      cmd_run_halt_out <= 16'h0000;
      sync_pulse_out <= 16'h0000;
      busy_out <= 1'b0;
    end else begin
      cmd_full_reset_out <= 16'h0000;
      cmd_load_config_out <= 16'h0000;
      cmd_run_begin_out <= 16'h0000;
      cmd_trig_force_out <= 16'h0000;
      cmd_run_halt_out <= 16'h0000;
      sync_pulse_out <= 16'h0000;
      unique case (state)
        sync_hub_pkg::ST_IDLE: begin
          busy_out <= 1'b0;
          if (reg_wr_in && reg_index_in == sync_hub_pkg::REG_CMD_WORD && reg_wdata_in[6:0] != 7'h00) begin
            pend <= {1'b0, reg_wdata_in[6:0]}; // see [RULE8]
            busy_out <= 1'b1;
            state <= sync_hub_pkg::ST_CHECK;
          end
        end
        sync_hub_pkg::ST_CHECK: begin
          // setup check: hub card must be a member, else drop the command
          if (!member_mask[hub_index_in]) begin
            pend <= 8'h00; // see [RULE4] see [RULE7]
            state <= sync_hub_pkg::ST_IDLE;
          end else begin
            if (!running) begin
              run_mask <= member_mask; // see [RULE3]
            end
            sync_cnt <= sync_hub_pkg::SYNC_CYCLES;
            state <= sync_hub_pkg::ST_SYNC;
          end
        end
        sync_hub_pkg::ST_SYNC: begin
          // a short sync pulse to members before any command goes out
          sync_pulse_out <= fan(sync_cnt == sync_hub_pkg::SYNC_CYCLES, run_mask); // see [RULE7]
          sync_cnt <= sync_cnt - 4'h1;
          if (sync_cnt == 4'h1) begin
            state <= sync_hub_pkg::ST_RESET;
          end
        end
        sync_hub_pkg::ST_RESET: begin
          if (pend[sync_hub_pkg::BIT_FULL_RESET]) begin
            cmd_full_reset_out <= run_mask; // see [RULE9]
            running <= 1'b0;
            armed <= 1'b0;
          end
          state <= sync_hub_pkg::ST_LOAD;
        end
        sync_hub_pkg::ST_LOAD: begin
          // explicit load, or implicit load of changed config before a start
          if (!running && (pend[sync_hub_pkg::BIT_LOAD_CONFIG] || (pend[sync_hub_pkg::BIT_RUN_BEGIN] && dirty))) begin
            cmd_load_config_out <= run_mask; // see [RULE10] see [RULE11] see [RULE12]
          end
          state <= sync_hub_pkg::ST_START;
        end
        sync_hub_pkg::ST_START: begin
          if (pend[sync_hub_pkg::BIT_RUN_BEGIN] && !running) begin
            cmd_run_begin_out <= run_mask; // see [RULE11]
            running <= 1'b1;
            armed <= 1'b0; // see [RULE16]
          end
          state <= sync_hub_pkg::ST_TRIG;
        end
        sync_hub_pkg::ST_TRIG: begin
          // arm after start so a joint write arms the new run
          if (pend[sync_hub_pkg::BIT_TRIG_ARM]) begin
            armed <= 1'b1; // see [RULE13] see [RULE20]
          end
          if (pend[sync_hub_pkg::BIT_TRIG_DISARM]) begin
            armed <= 1'b0; // see [RULE15]
          end
          if (pend[sync_hub_pkg::BIT_TRIG_FORCE] && running) begin
            cmd_trig_force_out <= run_mask; // see [RULE14]
          end
          state <= sync_hub_pkg::ST_HALT;
        end
        sync_hub_pkg::ST_HALT: begin
          if (pend[sync_hub_pkg::BIT_RUN_HALT] && running) begin
            cmd_run_halt_out <= run_mask; // see [RULE17]
            running <= 1'b0;
            armed <= 1'b0;
          end
          pend <= 8'h00;
          state <= sync_hub_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // joined trigger: any armed member trigger hits every member
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      group_trig_out <= 16'h0000;
    end else begin
      // members keep their own sources; only the detected event is shared
      group_trig_out <= fan(armed && running && |(trig_sync & run_mask), run_mask); // see [RULE5] see [RULE6]
    end
  end

  // mirrors of state for the cards and host
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      trig_armed_out <= 16'h0000;
      run_active_out <= 1'b0;
    end else begin
      trig_armed_out <= fan(armed, run_mask);
      run_active_out <= running;
    end
  end

  // wait request: done as soon as the hub card is ready
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wait_pend <= 1'b0;
      wait_done_out <= 1'b0;
    end else begin
      wait_done_out <= 1'b0;
      if (wait_pend && ready_sync[hub_index_in]) begin
        wait_pend <= 1'b0;
        wait_done_out <= 1'b1; // see [RULE19]
      end else if (reg_wr_in && reg_index_in == sync_hub_pkg::REG_CMD_WORD && reg_wdata_in[sync_hub_pkg::BIT_WAIT_DONE]) begin
        wait_pend <= 1'b1;
      end
    end
  end

  // start then arm ordering in a combined write; a disarm bit in the same
  // write beats the arm, so it is left out of the antecedent
  sequence s_start_arm;
    cmd_run_begin_out != 16'h0000 && pend[sync_hub_pkg::BIT_TRIG_ARM] && !pend[sync_hub_pkg::BIT_TRIG_DISARM];
  endsequence
  sequence s_start_bare;
    cmd_run_begin_out != 16'h0000 && !pend[sync_hub_pkg::BIT_TRIG_ARM];
  endsequence
  chk_start_then_arm: assert property (@(posedge clk_in) disable iff (srst_in)
    s_start_arm |=> ##1 (trig_armed_out == run_mask)) // see [RULE20]
    else $error("arm did not follow start");
  chk_start_disarmed: assert property (@(posedge clk_in) disable iff (srst_in)
    s_start_bare |=> ##1 (trig_armed_out == 16'h0000)) // see [RULE16]
    else $error("run began armed");
  // a mask write outside a run lands as written
  chk_mask_write: assert property (@(posedge clk_in) disable iff (srst_in)
    reg_wr_in && reg_index_in == sync_hub_pkg::REG_MEMBER_MASK && !running
    |=> member_mask == $past(reg_wdata_in[15:0])) // see [RULE1]
    else $error("mask write lost");
  // hub card missing from the mask: the command is dropped at once
  chk_hub_required: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_CHECK && !member_mask[hub_index_in] |=> state == sync_hub_pkg::ST_IDLE) // see [RULE7]
    else $error("command ran without hub card");
  // reset pulse reaches the group and ends the run
  chk_reset_fan: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_RESET && pend[sync_hub_pkg::BIT_FULL_RESET]
    |=> cmd_full_reset_out == run_mask && !running) // see [RULE9]
    else $error("reset not forwarded");
  // explicit load pulse
  chk_load_config: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_LOAD && !running && pend[sync_hub_pkg::BIT_LOAD_CONFIG]
    |=> cmd_load_config_out == run_mask) // see [RULE10]
    else $error("load not forwarded");
  // implicit load of a changed config ahead of a start
  chk_load_before: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_LOAD && !running && pend[sync_hub_pkg::BIT_RUN_BEGIN] && dirty
    |=> cmd_load_config_out == run_mask) // see [RULE11]
    else $error("changed config not loaded");
  // force reaches the whole running group
  chk_force_fan: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_TRIG && pend[sync_hub_pkg::BIT_TRIG_FORCE] && running
    |=> cmd_trig_force_out == run_mask) // see [RULE14]
    else $error("force not forwarded");
  // disarm leaves detection off
  chk_disarm_wins: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_TRIG && pend[sync_hub_pkg::BIT_TRIG_DISARM] |=> !armed) // see [RULE15]
    else $error("disarm ignored");
  // halt in a run stops it and tells the group
  chk_halt_run: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_HALT && running && pend[sync_hub_pkg::BIT_RUN_HALT]
    |=> cmd_run_halt_out == run_mask && !running) // see [RULE17]
    else $error("halt not forwarded");
  // the remaining group strobes stay inside the run's members
  chk_other_masked: assert property (@(posedge clk_in) disable iff (srst_in)
    ((cmd_load_config_out | cmd_trig_force_out | sync_pulse_out | group_trig_out) & ~run_mask) == 16'h0000) // see [RULE3]
    else $error("strobe to non-member");
  chk_halt_idle: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == sync_hub_pkg::ST_HALT && !running) |=> cmd_run_halt_out == 16'h0000) // see [RULE17]
    else $error("halt issued while idle");
  chk_fan_masked: assert property (@(posedge clk_in) disable iff (srst_in)
    ((cmd_run_begin_out | cmd_full_reset_out | cmd_run_halt_out) & ~run_mask) == 16'h0000) // see [RULE3]
    else $error("command to non-member");
  chk_mask_locked: assert property (@(posedge clk_in) disable iff (srst_in)
    running && reg_wr_in && reg_index_in == sync_hub_pkg::REG_MEMBER_MASK |=> $stable(member_mask)) // see [RULE12]
    else $error("mask changed in run");
  chk_sync_first: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(state == sync_hub_pkg::ST_SYNC) |-> sync_pulse_out == 16'h0000 ##1 sync_pulse_out == run_mask) // see [RULE7]
    else $error("sync pulse missing");
  chk_wait_hub: assert property (@(posedge clk_in) disable iff (srst_in)
    wait_pend && ready_sync[hub_index_in] |=> wait_done_out) // see [RULE19]
    else $error("wait not completed");
  chk_group_trig: assert property (@(posedge clk_in) disable iff (srst_in)
    armed && running && |(trig_sync & run_mask) |=> group_trig_out == run_mask) // see [RULE5]
    else $error("group trigger missing");
  chk_cmd_taken: assert property (@(posedge clk_in) disable iff (srst_in)
    state == sync_hub_pkg::ST_IDLE && reg_wr_in && reg_index_in == sync_hub_pkg::REG_CMD_WORD
    && reg_wdata_in[6:0] != 7'h00 |=> busy_out ##[1:12] !busy_out) // see [RULE8]
    else $error("command not finished");
endmodule : multi_card_sync_hub

// *** sim/host_driver_model.sv ***
/*
  host driver model: issues register writes and reads toward the sync hub.
  assumes one-cycle strobes, taken at the edge they are high, and read data one cycle later.
*/
`timescale 1ns/100ps
module host_driver_model (
  // clock
  input wire logic clk_in,
  // register port toward the hub
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [15:0] reg_index_out,
  output logic [31:0] reg_wdata_out,
  input wire logic [31:0] reg_rdata_in
);
  // idle bus at time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_index_out = 16'h0000;
    reg_wdata_out = 32'h0000_0000;
  end

  // only group commands and the mask are ever sent here; all else goes to the cards
  task automatic write_reg(input logic [15:0] idx, input logic [31:0] data);
    @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_index_out <= idx;
    reg_wdata_out <= data;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    // released lines show junk so a stale value can never pass for a live one
    reg_index_out <= ~idx;
    reg_wdata_out <= ~data;
  endtask : write_reg

  // read: strobe taken at one edge, data sampled at the next
  task automatic read_reg(input logic [15:0] idx, output logic [31:0] data);
    @(posedge clk_in);
    reg_rd_out <= 1'b1;
    reg_index_out <= idx;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_index_out <= ~idx;
    @(posedge clk_in);
    data = reg_rdata_in;
  endtask : read_reg
endmodule : host_driver_model

// *** sim/multi_card_sync_hub_bench.sv ***
/*
  bench for the sync hub: random member mask and hub slot, host model, command walk.
  assumes every command sequence settles within 30 cycles of its write.
*/
`timescale 1ns/100ps
module multi_card_sync_hub_bench;
  logic clk_in, srst_in, config_changed_in, reg_wr, reg_rd, reg_err_out;
  logic run_active_out, busy_out, wait_done_out, err_seen, done_seen;
  logic [15:0] reg_index, member_trig_in, member_ready_in, mask;
  logic [31:0] reg_wdata, reg_rdata_out, rd, seed;
  logic [3:0] hub_index_in;
  logic [15:0] rst_o, load_o, begin_o, force_o, halt_o, sync_o, group_o, armed_o;
  logic [15:0] acc [8]; // strobes ORed over one watch window
  int mismatches, comparisons;

  host_driver_model host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_index_out(reg_index), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata_out));

  multi_card_sync_hub dut (.clk_in(clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_index_in(reg_index), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out),
    .reg_err_out(reg_err_out), .config_changed_in(config_changed_in), .member_trig_in(member_trig_in),
    .member_ready_in(member_ready_in), .hub_index_in(hub_index_in), .cmd_full_reset_out(rst_o),
    .cmd_load_config_out(load_o), .cmd_run_begin_out(begin_o), .cmd_trig_force_out(force_o),
    .cmd_run_halt_out(halt_o), .sync_pulse_out(sync_o), .group_trig_out(group_o),
    .trig_armed_out(armed_o), .run_active_out(run_active_out), .busy_out(busy_out),
    .wait_done_out(wait_done_out));

  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // repeatable pseudo random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // expected group: random cards, hub card forced in, its neighbour left out to run alone
  function automatic logic [15:0] member_mask(input logic [15:0] r, input logic [3:0] hub);
    logic [15:0] m;
    m = r & ~(16'h0001 << (hub + 4'h1));
    return m | (16'h0001 << hub);
  endfunction : member_mask

  // one comparison, reported at once on mismatch
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // OR every strobe over n cycles; sampled on the falling edge where all is settled
  task automatic watch(input int n);
    acc = '{default: 16'h0000};
    err_seen = 1'b0;
    done_seen = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      acc[0] |= rst_o;
      acc[1] |= load_o;
      acc[2] |= begin_o;
      acc[3] |= force_o;
      acc[4] |= halt_o;
      acc[5] |= sync_o;
      acc[6] |= group_o;
      err_seen |= reg_err_out;
      done_seen |= wait_done_out;
    end
  endtask : watch

  // command write, then watch long enough for the whole walk
  task automatic issue(input logic [31:0] cmd);
    host.write_reg(sync_hub_pkg::REG_CMD_WORD, cmd);
    watch(30);
    check("busy", {31'h0, busy_out}, 32'h0);
  endtask : issue

  // verdict and end of run
  task automatic complete_run;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // watchdog: the walk needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    complete_run();
  end

  // main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    seed = xorshift(32'h0000_0F73);
    hub_index_in = seed[19:16];
    mask = member_mask(seed[15:0], seed[19:16]);
    srst_in = 1'b1;
    config_changed_in = 1'b0;
    member_trig_in = 16'h0000;
    member_ready_in = 16'h0000;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    host.read_reg(sync_hub_pkg::REG_MEMBER_MASK, rd);
    check("mask reset", rd, sync_hub_pkg::MASK_RESET);
    issue(32'h02);
    check("dropped", {16'h0, acc[1] | acc[5]}, 32'h0);
    host.write_reg(sync_hub_pkg::REG_MEMBER_MASK, {16'hFFFF, mask});
    host.read_reg(sync_hub_pkg::REG_MEMBER_MASK, rd);
    check("mask read", rd, {16'h0, mask});
    $display("end of test: mask");
    issue(32'h02);
    check("load", acc[1], mask);
    check("no start", acc[2], 16'h0);
    check("sync", acc[5], mask);
    issue(32'h01);
    check("reset", acc[0], mask);
    @(posedge clk_in);
    config_changed_in <= 1'b1;
    @(posedge clk_in);
    config_changed_in <= 1'b0;
    issue(32'h0C);
    check("start load", acc[1], mask);
    check("start", acc[2], mask);
    check("armed", armed_o, mask);
    check("running", run_active_out, 1'b1);
    $display("end of test: start and arm");
    host.write_reg(sync_hub_pkg::REG_MEMBER_MASK, 32'h0000_FFFF);
    watch(3);
    check("mask refused", err_seen, 1'b1);
    host.read_reg(sync_hub_pkg::REG_MEMBER_MASK, rd);
    check("mask kept", rd, {16'h0, mask});
    @(posedge clk_in);
    member_trig_in <= ~mask;
    watch(10);
    check("outsider trig", acc[6], 16'h0);
    @(posedge clk_in);
    member_trig_in <= 16'h0001 << hub_index_in;
    watch(10);
    check("group trig", acc[6], mask);
    @(posedge clk_in);
    member_trig_in <= 16'h0000;
    issue(32'h10);
    check("force", acc[3], mask);
    issue(32'h20);
    check("disarmed", armed_o, 16'h0);
    @(posedge clk_in);
    member_trig_in <= mask;
    watch(10);
    check("ignored trig", acc[6], 16'h0);
    @(posedge clk_in);
    member_trig_in <= 16'h0000;
    issue(32'h40);
    check("halt", acc[4], mask);
    check("stopped", run_active_out, 1'b0);
    issue(32'h40);
    check("idle halt", acc[4], 16'h0);
    $display("end of test: trigger and halt");
    issue(32'h04);
    check("start disarmed", armed_o, 16'h0);
    issue(32'h08);
    check("late arm", armed_o, mask);
    issue(32'h40);
    issue(32'h100);
    check("wait pending", done_seen, 1'b0);
    @(posedge clk_in);
    member_ready_in <= 16'h0001 << hub_index_in;
    watch(10);
    check("wait done", done_seen, 1'b1);
    $display("end of test: arm and wait");
    complete_run();
  end
endmodule : multi_card_sync_hub_bench
